/* File: flyback_cycle_request_control.sv */
// flyback primary takeover, frequency skip and secondary request sequencing
// Functional notes
// - after restart the primary controls until a successful handshake
// - primary waits one restart period, listening for requests
// - two requests about 30 us apart in the wait give secondary control
// - no requests in the wait: primary switches itself until handshake
// - gate suppressed for requests 83 to 142 us after last conduction
// - controller requests cycles; accepted ones go over the link
// - acknowledge is given when the link pulse is sent
// - in discontinuous mode rectifier turns off below its threshold
// - in continuous mode rectifier turns off when request is sent
// - minimum off-time after conduction before the next request
// - after request block until sense falling edge or 30 us timeout
// - rectifier on only if cycle requested and negative edge seen
// - rectifier gate held low until the start-up load check finds the output present
// - start-up load check marks the rectifier output open or present
// - open or grounded rectifier output stops all requests
// - valley switching on in discontinuous, off in continuous mode
// - discontinuous requests only at ringing peaks while the valley window runs
// - valley gating lasts 20 us after discontinuous detection
// - 1 us blanking ignores sense ringing below ground
`timescale 1ns/1ns
`default_nettype none
module flyback_cycle_request_control #(
    parameter int RESTART_CYC = flyback_pkg::RESTART_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic restart_event,
    input wire logic link_rx_pulse,
    input wire logic primary_off_edge,
    input wire logic cycle_request_in,
    input wire logic sense_fall_in,
    input wire logic sense_above_vout_in,
    input wire logic sense_below_threshold_in,
    input wire logic dcm_detect_in,
    input wire logic load_high_in,
    input wire logic load_short_in,
    output logic power_gate_drive,
    output logic primary_in_control,
    output logic link_tx_pulse,
    output logic request_ack,
    output logic rectifier_gate_drive,
    output logic rectifier_pulldown_en,
    output logic forward_timing_out,
    output logic rectifier_open_fault
);
    import flyback_pkg::*;

    // the wait counter must hold the whole restart period
    if (RESTART_CYC < 2 || RESTART_CYC >= (1 << RST_W)) begin : g_bad_restart
        $error("RESTART_CYC out of range for the wait counter");
    end

    // ************************************
    // input synchronisers
    // ************************************
    localparam int NS = 9;
    logic [NS-1:0] s1_reg, s2_reg, s3_reg, in_now;
    assign in_now = {restart_event, link_rx_pulse, cycle_request_in, sense_fall_in, sense_above_vout_in,
                     sense_below_threshold_in, dcm_detect_in, load_high_in, load_short_in};
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= in_now;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // a change counts only once the second and third stage agree
    logic [NS-1:0] lvl_reg, lvl_next, rise;
    assign lvl_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_reg);
    assign rise = lvl_next & ~lvl_reg;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) lvl_reg <= '0;
        else lvl_reg <= lvl_next;
    end
    wire restart_p = rise[8];
    wire link_p = rise[7];
    wire req_p = rise[6];
    wire fall_p = rise[5];
    wire above_vout = lvl_reg[4];
    wire below_thr = lvl_reg[3];
    wire dcm = lvl_reg[2];
    wire load_high = lvl_reg[1];
    wire load_short = lvl_reg[0];

    function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
        inc_sat = (&v) ? v : v + 1'b1;
    endfunction : inc_sat

    // ************************************
    // primary side: wait and listen
    // ************************************
    pri_state_e pri_reg, pri_next;
    logic [RST_W-1:0] wait_reg, wait_next;
    logic [CNT_W-1:0] gap_reg, since_cond_reg;
    logic seen_reg, seen_next;
    wire wait_done = (wait_reg >= RST_W'(RESTART_CYC - 1));
    wire pair_ok = seen_reg && (gap_reg >= CNT_W'(PAIR_SPACING_CYC - PAIR_TOL_CYC))
                   && (gap_reg <= CNT_W'(PAIR_SPACING_CYC + PAIR_TOL_CYC));
    always_comb begin
        pri_next = pri_reg;
        wait_next = wait_reg;
        seen_next = seen_reg;
        unique case (pri_reg)
            PRI_WAIT: begin
                wait_next = wait_done ? wait_reg : wait_reg + 1'b1;
                if (link_p) seen_next = 1'b1;
                if (link_p && pair_ok) pri_next = PRI_SLAVE;
                else if (wait_done) pri_next = PRI_OWN;
            end
            PRI_OWN: begin
                if (link_p) seen_next = 1'b1;
                if (link_p && pair_ok) pri_next = PRI_SLAVE;
            end
            PRI_SLAVE: ;
        endcase
        if (restart_p) begin
            pri_next = PRI_WAIT;
            wait_next = '0;
            seen_next = 1'b0;
        end
    end
    // frequency skip band measured from the last primary conduction
    wire in_skip = (since_cond_reg >= CNT_W'(SKIP_LO_CYC)) && (since_cond_reg <= CNT_W'(SKIP_HI_CYC));
    wire pri_fire = (pri_reg == PRI_SLAVE) && link_p && !in_skip;
    wire own_fire = (pri_reg == PRI_OWN) && (since_cond_reg >= CNT_W'(SKIP_HI_CYC + 1));
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pri_reg <= PRI_WAIT;
            wait_reg <= '0;
            seen_reg <= 1'b0;
            gap_reg <= '0;
            since_cond_reg <= '1;
            power_gate_drive <= 1'b0;
            primary_in_control <= 1'b1;
        end else begin
            pri_reg <= pri_next;
            wait_reg <= wait_next;
            seen_reg <= seen_next;
            gap_reg <= link_p ? '0 : inc_sat(gap_reg);
            since_cond_reg <= (pri_fire || own_fire) ? '0 : inc_sat(since_cond_reg);
            power_gate_drive <= pri_fire || own_fire;
            primary_in_control <= (pri_next != PRI_SLAVE);
        end
    end

    // ************************************
    // secondary side: load check at start-up
    // ************************************
    logic [CNT_W-1:0] chk_reg;
    logic chk_done_reg, open_reg;
    wire chk_end = !chk_done_reg && (chk_reg == CNT_W'(LOAD_CHECK_CYC - 1));
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            chk_reg <= '0;
            chk_done_reg <= 1'b0;
            open_reg <= 1'b0;
        end else begin
            if (!chk_done_reg) chk_reg <= chk_reg + 1'b1;
            if (chk_end) begin
                chk_done_reg <= 1'b1;
                open_reg <= load_high || load_short;
            end
        end
    end

    // ************************************
    // secondary side: request gating
    // ************************************
    logic inhibit_reg, rect_reg, armed_reg;
    logic [CNT_W-1:0] inh_cnt_reg, off_cnt_reg, blank_reg, qr_reg;
    logic dcm_d_reg;
    wire sec_ok = chk_done_reg && !open_reg;
    wire min_off_ok = (off_cnt_reg >= CNT_W'(MIN_OFF_CYC));
    wire qr_active = dcm && (qr_reg < CNT_W'(QR_WINDOW_CYC));
    wire valley_ok = !qr_active || above_vout;
    wire blanked = (blank_reg < CNT_W'(BLANK_CYC));
    wire fall_ok = fall_p && !blanked;
    wire inh_timeout = (inh_cnt_reg >= CNT_W'(INHIBIT_TIMEOUT_CYC - 1));
    // requests that meet an inhibit are dropped, never queued
    wire send = req_p && sec_ok && !inhibit_reg && min_off_ok && valley_ok;
    wire rect_on = armed_reg && fall_ok;
    wire rect_off = send || (dcm && below_thr) || !sec_ok;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            inhibit_reg <= 1'b0;
            armed_reg <= 1'b0;
            rect_reg <= 1'b0;
            inh_cnt_reg <= '0;
            off_cnt_reg <= '1;
            blank_reg <= '1;
            qr_reg <= '0;
            dcm_d_reg <= 1'b0;
            link_tx_pulse <= 1'b0;
            request_ack <= 1'b0;
            rectifier_gate_drive <= 1'b0;
            rectifier_pulldown_en <= 1'b1;
            forward_timing_out <= 1'b0;
            rectifier_open_fault <= 1'b0;
        end else begin
            if (send) inhibit_reg <= 1'b1;
            else if (inhibit_reg && (fall_ok || inh_timeout)) inhibit_reg <= 1'b0;
            inh_cnt_reg <= send ? '0 : inc_sat(inh_cnt_reg);
            if (send) armed_reg <= 1'b1;
            else if (rect_on || (inhibit_reg && inh_timeout)) armed_reg <= 1'b0;
            if (rect_off) rect_reg <= 1'b0;
            else if (rect_on) rect_reg <= 1'b1;
            off_cnt_reg <= primary_off_edge ? '0 : inc_sat(off_cnt_reg);
            blank_reg <= send ? '0 : inc_sat(blank_reg);
            dcm_d_reg <= dcm;
            qr_reg <= (dcm && !dcm_d_reg) ? '0 : inc_sat(qr_reg);
            link_tx_pulse <= send;
            request_ack <= send;
            rectifier_gate_drive <= !rect_off && (rect_reg || rect_on);
            rectifier_pulldown_en <= rect_off || !(rect_reg || rect_on);
            forward_timing_out <= fall_ok;
            rectifier_open_fault <= chk_done_reg && open_reg;
        end
    end
endmodule : flyback_cycle_request_control
`default_nettype wire

/* File: flyback_pkg.sv */
// constants and types for the flyback cycle request control block
package flyback_pkg;
    // ************************************
    // timing
    // ************************************
    localparam int CLK_MHZ = 100;
    localparam int RESTART_PERIOD_MS = 82;
    localparam int RESTART_PERIOD_CYC = RESTART_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int PAIR_SPACING_US = 30;
    localparam int PAIR_SPACING_CYC = PAIR_SPACING_US * CLK_MHZ;
    localparam int PAIR_TOL_CYC = PAIR_SPACING_CYC / 4;
    localparam int SKIP_LO_US = 83;
    localparam int SKIP_LO_CYC = SKIP_LO_US * CLK_MHZ;
    localparam int SKIP_HI_US = 142;
    localparam int SKIP_HI_CYC = SKIP_HI_US * CLK_MHZ;
    localparam int INHIBIT_TIMEOUT_US = 30;
    localparam int INHIBIT_TIMEOUT_CYC = INHIBIT_TIMEOUT_US * CLK_MHZ;
    localparam int QR_WINDOW_US = 20;
    localparam int QR_WINDOW_CYC = QR_WINDOW_US * CLK_MHZ;
    localparam int BLANK_US = 1;
    localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
    localparam int MIN_OFF_NS = 2000;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int LOAD_CHECK_CYC = 64;
    localparam int CNT_W = 24;
    localparam int RST_W = 24;

    typedef enum logic [1:0] {
        PRI_WAIT,
        PRI_OWN,
        PRI_SLAVE
    } pri_state_e;
endpackage : flyback_pkg

/* File: flyback_props.sv */
// assertions on the ports of the flyback cycle request control block
`timescale 1ns/1ns
`default_nettype none
module flyback_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic link_tx_pulse,
    input wire logic request_ack,
    input wire logic rectifier_gate_drive,
    input wire logic rectifier_pulldown_en,
    input wire logic rectifier_open_fault,
    input wire logic forward_timing_out,
    input wire logic power_gate_drive
);
    // ****************
    // port checks
    // ****************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_ack_with_tx: assert property (request_ack == link_tx_pulse) else $error("ack apart from link pulse");
    a_pulldown_excl: assert property (rectifier_pulldown_en == !rectifier_gate_drive) else $error("pulldown wrong");
    a_ccm_gate_off: assert property (link_tx_pulse |-> !rectifier_gate_drive) else $error("gate on at send");
    a_no_resend: assert property (link_tx_pulse |=> !link_tx_pulse [*8]) else $error("request not blocked");
    a_gate_cause: assert property ($rose(rectifier_gate_drive) |-> forward_timing_out || $past(forward_timing_out))
        else $error("gate on without sense edge");
    a_fault_gate: assert property (rectifier_open_fault |=> !rectifier_gate_drive) else $error("gate on in fault");
    a_fault_no_tx: assert property (rectifier_open_fault |-> !link_tx_pulse) else $error("send in fault");
    a_power_pulse: assert property (power_gate_drive |=> !power_gate_drive) else $error("gate pulse too long");
endmodule : flyback_props
bind flyback_cycle_request_control flyback_props props_u (.sys_clk(sys_clk), .reset(reset),
    .link_tx_pulse(link_tx_pulse), .request_ack(request_ack), .rectifier_gate_drive(rectifier_gate_drive),
    .rectifier_pulldown_en(rectifier_pulldown_en), .rectifier_open_fault(rectifier_open_fault),
    .forward_timing_out(forward_timing_out), .power_gate_drive(power_gate_drive));
`default_nettype wire

/* File: flyback_ctrl_model.sv */
// behavioural model of the external multi-output controller
`timescale 1ns/1ns
`default_nettype none
module flyback_ctrl_model (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic request_ack,
    output logic cycle_request_in,
    output int acks
);
    // ****************
    // request issue
    // ****************
    initial begin
        cycle_request_in = 1'b0;
        acks = 0;
    end
    // held long enough to clear the input synchroniser
    always @(posedge go) begin
        @(posedge sys_clk);
        #1 cycle_request_in = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1 cycle_request_in = 1'b0;
    end
    always @(posedge sys_clk) if (request_ack === 1'b1) acks <= acks + 1;
endmodule : flyback_ctrl_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the flyback cycle request control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import flyback_pkg::*;
    localparam int RC = 5000;
    logic sys_clk, reset, restart_event, link_rx_pulse, primary_off_edge, sense_fall_in, load_high_in, go;
    logic sense_above_vout_in, sense_below_threshold_in, dcm_detect_in, load_short_in;
    int fw = 0;
    logic power_gate_drive, primary_in_control, link_tx_pulse, request_ack, cycle_request_in;
    logic rectifier_gate_drive, rectifier_pulldown_en, forward_timing_out, rectifier_open_fault;
    int acks, pg = 0, err_count = 0, n_checks = 0;
    flyback_cycle_request_control #(.RESTART_CYC(RC)) dut_u (.sys_clk(sys_clk), .reset(reset),
        .restart_event(restart_event), .link_rx_pulse(link_rx_pulse), .primary_off_edge(primary_off_edge),
        .cycle_request_in(cycle_request_in), .sense_fall_in(sense_fall_in),
        .sense_above_vout_in(sense_above_vout_in), .sense_below_threshold_in(sense_below_threshold_in),
        .dcm_detect_in(dcm_detect_in), .load_high_in(load_high_in),
        .load_short_in(load_short_in), .power_gate_drive(power_gate_drive), .primary_in_control(primary_in_control),
        .link_tx_pulse(link_tx_pulse), .request_ack(request_ack), .rectifier_gate_drive(rectifier_gate_drive),
        .rectifier_pulldown_en(rectifier_pulldown_en), .forward_timing_out(forward_timing_out),
        .rectifier_open_fault(rectifier_open_fault));
    flyback_ctrl_model ctrl_u (.sys_clk(sys_clk), .go(go), .request_ack(request_ack),
        .cycle_request_in(cycle_request_in), .acks(acks));
    // ****************
    // helpers
    // ****************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (power_gate_drive === 1'b1) pg <= pg + 1;
    always @(posedge sys_clk) if (forward_timing_out === 1'b1) fw <= fw + 1;
    task automatic chk(input logic [31:0] v, input logic [31:0] e);
        n_checks++;
        if (v !== e) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, v, e);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic req(output int a);
        int a0;
        a0 = acks;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(13);
        a = acks - a0;
    endtask : req
    task automatic fall;
        sense_fall_in = 1'b1;
        cyc(2);
        sense_fall_in = 1'b0;
        cyc(8);
    endtask : fall
    task automatic lp;
        link_rx_pulse = 1'b1;
        cyc(3);
        link_rx_pulse = 1'b0;
        cyc(8);
    endtask : lp
    task automatic do_reset;
        reset = 1'b1;
        cyc(16);
        chk(primary_in_control, 1);
        chk(rectifier_pulldown_en, 1);
        reset = 1'b0;
        cyc(LOAD_CHECK_CYC + 20);
        primary_off_edge = 1'b1;
        cyc(1);
        primary_off_edge = 1'b0;
        cyc(MIN_OFF_CYC + 10);
    endtask : do_reset
    // ****************
    // scenarios
    // ****************
    task automatic t_send;
        int a;
        req(a); chk(a, 1);
        req(a); chk(a, 0);
        cyc(BLANK_CYC); fall; chk(rectifier_gate_drive, 1);
        req(a); chk(a, 1);
        chk(rectifier_gate_drive, 0);
        fall; chk(rectifier_gate_drive, 0);
        cyc(INHIBIT_TIMEOUT_CYC); req(a); chk(a, 1);
    endtask : t_send
    task automatic t_listen;
        int p;
        restart_event = 1'b1; cyc(3); restart_event = 1'b0; cyc(10);
        chk(primary_in_control, 1);
        lp; cyc(PAIR_SPACING_CYC - 11); lp; cyc(10); chk(primary_in_control, 0);
        cyc(SKIP_HI_CYC + 500); p = pg; lp; chk(pg - p, 1);
        cyc(SKIP_LO_CYC + 1000); p = pg; lp; chk(pg - p, 0);
        cyc(6000); p = pg; lp; chk(pg - p, 1);
        restart_event = 1'b1; cyc(3); restart_event = 1'b0; cyc(RC + 20);
        chk(primary_in_control, 1);
        p = pg; cyc(SKIP_HI_CYC + 200); chk(pg > p, 1);
    endtask : t_listen
    task automatic t_dcm;
        int a;
        int f;
        dcm_detect_in = 1'b1; sense_above_vout_in = 1'b0; cyc(10);
        req(a); chk(a, 0);
        sense_above_vout_in = 1'b1;
        req(a); chk(a, 1);
        cyc(BLANK_CYC); f = fw; fall; chk(fw - f, 1);
        chk(rectifier_gate_drive, 1);
        sense_below_threshold_in = 1'b1; cyc(8); chk(rectifier_gate_drive, 0);
        sense_below_threshold_in = 1'b0; sense_above_vout_in = 1'b0;
        cyc(QR_WINDOW_CYC); req(a); chk(a, 1);
        dcm_detect_in = 1'b0; sense_above_vout_in = 1'b1;
    endtask : t_dcm
    task automatic t_fault;
        int a;
        load_high_in = 1'b1;
        do_reset; chk(rectifier_open_fault, 1);
        req(a); chk(a, 0);
        load_high_in = 1'b0; load_short_in = 1'b1;
        do_reset; chk(rectifier_open_fault, 1);
        req(a); chk(a, 0);
    endtask : t_fault
    initial begin
        reset = 1'b1; restart_event = 1'b0; link_rx_pulse = 1'b0; primary_off_edge = 1'b0;
        sense_fall_in = 1'b0; load_high_in = 1'b0; go = 1'b0;
        sense_above_vout_in = 1'b1; sense_below_threshold_in = 1'b0; dcm_detect_in = 1'b0; load_short_in = 1'b0;
        do_reset; chk(rectifier_open_fault, 0);
        t_send;
        t_listen;
        t_dcm;
        t_fault;
        conclude;
    end
    initial begin
        #900000;
        err_count++;
        conclude;
    end
endmodule : tb
`default_nettype wire
